// >>> rtl/ers_if.sv
// Conditioned external trigger signal between synchroniser and control
`timescale 1ns/10ps
`default_nettype none
interface ers_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// >>> rtl/ers_sync.sv
// Synchroniser, debug freeze and edge detector for the external trigger
`timescale 1ns/10ps
`default_nettype none
module ers_sync
  import limit_timer_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ers_pin_i,
  input  wire logic debug_i,
  ers_if.src        ers
);

  logic meta;
  logic sync;
  logic hold;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_hold;
  logic next_prev;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    next_meta = ers_pin_i;
    next_sync = meta;
    next_hold = debug_i ? hold : sync;
    next_prev = hold;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= LEVEL_RESET;
      sync <= LEVEL_RESET;
      hold <= LEVEL_RESET;
      prev <= LEVEL_RESET;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      hold <= next_hold;
      prev <= next_prev;
    end
  end

  assign ers.level = hold;
  assign ers.rise  = hold & ~prev;
  assign ers.fall  = ~hold & prev;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_debug_quiet;
    @(posedge clk_i) disable iff (reset_i)
      debug_i ##1 debug_i |-> !ers.rise && !ers.fall;
  endproperty
  a_debug_quiet: assert property (p_debug_quiet) else $error("trigger edge seen in debug");

endmodule
`default_nettype wire

// >>> rtl/limit_timer_mode_control.sv
// Mode control and counter of an 8-bit period timer with hardware limit
`timescale 1ns/10ps
`default_nettype none
module limit_timer_mode_control
  import limit_timer_pkg::*;
#(
  parameter int CNT_W = COUNT_W
) (
  input  wire logic             CLK_I,
  input  wire logic             RESET_I,
  input  wire logic [MODE_W-1:0] MODE_I,
  input  wire logic [CNT_W-1:0] PERIOD_I,
  input  wire logic             ON_WR_I,
  input  wire logic             ON_WDATA_I,
  input  wire logic             ERS_I,
  input  wire logic             DEBUG_I,
  output var  logic [CNT_W-1:0] COUNT_O,
  output var  logic             ON_O,
  output var  logic             MATCH_O,
  output var  logic             RUNNING_O
);

  if (CNT_W < 2) begin : g_bad_width
    $error("CNT_W must be at least 2");
  end

  // ----------------------------------------------------------------
  // Trigger conditioning
  // ----------------------------------------------------------------
  ers_if ers ();

  ers_sync u_sync (
    .clk_i     (CLK_I),
    .reset_i   (RESET_I),
    .ers_pin_i (ERS_I),
    .debug_i   (DEBUG_I),
    .ers       (ers)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count;
  logic             on;
  logic             match_q;
  logic             run_q;
  run_state_t       state;
  logic [CNT_W-1:0] next_count;
  logic             next_on;
  logic             next_run;
  run_state_t       next_state;
  logic [1:0]       fam;
  logic [2:0]       sub;
  logic             run;
  logic             clr;
  logic             trig;
  logic             lvl_act;
  logic             match;

  // ----------------------------------------------------------------
  // Mode decode and next values
  // ----------------------------------------------------------------
  always_comb begin
    fam        = MODE_I[FAM_HI:FAM_LO];
    sub        = MODE_I[SUB_HI:SUB_LO];
    run        = 1'h0;
    clr        = 1'h0;
    next_state = state;
    lvl_act    = (sub == SUB_6) ? ers.level : ~ers.level;
    case (sub)
      SUB_1, SUB_4, SUB_6: trig = ers.rise;
      SUB_2, SUB_5, SUB_7: trig = ers.fall;
      SUB_3:               trig = ers.rise | ers.fall;
      default:             trig = 1'h0;
    endcase
    case (fam)
      FAM_FREE: begin
        case (sub)
          SUB_1: run = on & ers.level;
          SUB_2: run = on & ~ers.level;
          SUB_3, SUB_4, SUB_5: begin
            run = on;
            clr = on & trig;
          end
          SUB_6, SUB_7: begin
            run = on & lvl_act;
            clr = on & ~lvl_act;
          end
          default: run = on;
        endcase
      end
      FAM_ONESHOT: begin
        if (sub == SUB_0) begin
          run = on;
        end else if (state == ST_RUN) begin
          run = on;
          case (sub)
            SUB_4, SUB_5: clr = trig;
            SUB_6:        clr = ~ers.level;
            SUB_7:        clr = ers.level;
            default:      clr = 1'h0;
          endcase
        end else if (on && trig) begin
          next_state = ST_RUN;
        end
      end
      FAM_MONO: begin
        case (sub)
          SUB_1, SUB_2, SUB_3: begin
            if (state == ST_RUN) begin
              run = on;
            end else if (on && trig) begin
              next_state = ST_RUN;
            end
          end
          SUB_6, SUB_7: begin
            clr = on & ~lvl_act;
            run = on & lvl_act & (state == ST_RUN);
            if (!lvl_act) begin
              next_state = ST_IDLE;
            end else if (on && state == ST_IDLE) begin
              next_state = ST_RUN;
            end
          end
          default: run = 1'h0;
        endcase
      end
      default: run = 1'h0;
    endcase

    match = run & ~clr & (count == PERIOD_I);
    // Held in reset does not count as running
    next_run = run & ~clr;

    if (clr || match) begin
      next_count = '0;
    end else if (run) begin
      next_count = count + CNT_W'(1);
    end else begin
      next_count = count;
    end

    next_on = on;
    if (match && fam == FAM_ONESHOT) begin
      next_on    = 1'h0;
      next_state = ST_IDLE;
    end
    if (match && fam == FAM_MONO) begin
      next_state = (sub == SUB_6 || sub == SUB_7) ? ST_SPENT : ST_IDLE;
    end
    if (!on) begin
      next_state = ST_IDLE;
    end
    if (ON_WR_I) begin
      next_on = ON_WDATA_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      count   <= '0;
      on      <= ON_RESET;
      match_q <= 1'h0;
      run_q   <= 1'h0;
      state   <= ST_IDLE;
    end else begin
      count   <= next_count;
      on      <= next_on;
      match_q <= match;
      run_q   <= next_run;
      state   <= next_state;
    end
  end

  assign COUNT_O   = count;
  assign ON_O      = on;
  assign MATCH_O   = match_q;
  assign RUNNING_O = run_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  property p_reserved_hold;
    (fam == 2'h3) |=> count == $past(count);
  endproperty
  a_reserved_hold: assert property (p_reserved_hold) else $error("reserved mode moved count");

  property p_soft_gate;
    (MODE_I == 5'h00 && on && count != PERIOD_I) |=> count == CNT_W'($past(count) + CNT_W'(1));
  endproperty
  a_soft_gate: assert property (p_soft_gate) else $error("software gate failed to count");

  property p_gate_hi;
    (MODE_I == 5'h01 && !ers.level) |=> count == $past(count);
  endproperty
  a_gate_hi: assert property (p_gate_hi) else $error("gate low but counted");

  property p_rise_reset;
    (MODE_I == 5'h04 && on && ers.rise) |=> count == '0;
  endproperty
  a_rise_reset: assert property (p_rise_reset) else $error("rising edge did not reset");

  property p_low_reset;
    (MODE_I == 5'h06 && on && !ers.level) [*2] |=> count == '0;
  endproperty
  a_low_reset: assert property (p_low_reset) else $error("low level did not hold reset");

  property p_oneshot_end;
    (fam == FAM_ONESHOT && match && !ON_WR_I) |=> !on && count == '0 ##1 count == '0;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot did not stop");

  property p_mono_end;
    (fam == FAM_MONO && match && !ON_WR_I) |=> on && count == '0 && state != ST_RUN;
  endproperty
  a_mono_end: assert property (p_mono_end) else $error("monostable end wrong");

  property p_edge_wait;
    (MODE_I == 5'h09 && state == ST_IDLE && !ers.rise) |=> count == $past(count) && state == ST_IDLE;
  endproperty
  a_edge_wait: assert property (p_edge_wait) else $error("one-shot started without edge");

  property p_limit_reset;
    (MODE_I == 5'h0c && state == ST_RUN && on && ers.rise) |=> count == '0 && state == ST_RUN;
  endproperty
  a_limit_reset: assert property (p_limit_reset) else $error("hardware limit reset missed");

  property p_mono_start;
    (MODE_I == 5'h11 && on && state == ST_IDLE && ers.rise && !ON_WR_I) |=> state == ST_RUN;
  endproperty
  a_mono_start: assert property (p_mono_start) else $error("monostable did not start");

  property p_mono_level;
    (MODE_I == 5'h16 && on && !ers.level) |=> count == '0 && !run_q;
  endproperty
  a_mono_level: assert property (p_mono_level) else $error("level monostable not held");

  property p_soft_start;
    (MODE_I == 5'h08 && !on && !ON_WR_I) |=> count == $past(count);
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("one-shot counted while off");

  sequence s_reenable;
    !on ##1 on;
  endsequence

  property p_fresh_edge;
    s_reenable ##0 (MODE_I == 5'h09 && !ers.rise) |=> state == ST_IDLE;
  endproperty
  a_fresh_edge: assert property (p_fresh_edge) else $error("resumed without fresh edge");

endmodule
`default_nettype wire

// >>> rtl/limit_timer_pkg.sv
// Shared constants and types of the limit timer mode control
package limit_timer_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          COUNT_W     = 8;
  localparam int          MODE_W      = 5;
  localparam int          FAM_HI      = 4;
  localparam int          FAM_LO      = 3;
  localparam int          SUB_HI      = 2;
  localparam int          SUB_LO      = 0;
  localparam logic        ON_RESET    = 1'h0;
  localparam logic        LEVEL_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Mode families
  // ----------------------------------------------------------------
  localparam logic [1:0]  FAM_FREE    = 2'h0;
  localparam logic [1:0]  FAM_ONESHOT = 2'h1;
  localparam logic [1:0]  FAM_MONO    = 2'h2;

  // ----------------------------------------------------------------
  // Sub-mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  SUB_0       = 3'h0;
  localparam logic [2:0]  SUB_1       = 3'h1;
  localparam logic [2:0]  SUB_2       = 3'h2;
  localparam logic [2:0]  SUB_3       = 3'h3;
  localparam logic [2:0]  SUB_4       = 3'h4;
  localparam logic [2:0]  SUB_5       = 3'h5;
  localparam logic [2:0]  SUB_6       = 3'h6;
  localparam logic [2:0]  SUB_7       = 3'h7;

  // ----------------------------------------------------------------
  // Trigger source limits, in timer clocks
  // ----------------------------------------------------------------
  localparam int          MIN_EDGE_GAP_CLKS  = 6;
  localparam int          MIN_LEVEL_CLKS     = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SPENT} run_state_t;

endpackage

// >>> tb/ers_source.sv
// External trigger source model with edge spacing limits
`timescale 1ns/10ps
`default_nettype none
module ers_source (
  input  wire logic clk_i,
  input  wire logic level_i,
  output var  logic ers_o
);
  logic       want;
  logic [3:0] gap;

  initial begin
    ers_o = 1'h0;
    want  = 1'h0;
    gap   = 4'h0;
  end

  always @(posedge clk_i) begin
    want <= level_i;
  end

  always @(negedge clk_i) begin
    if (want != ers_o && gap >= 4'h6) begin
      ers_o <= want;
      gap   <= 4'h0;
    end else if (gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_limit_timer_mode_control.sv
// Self-checking bench of the limit timer mode control
`timescale 1ns/10ps
`default_nettype none
module tb_limit_timer_mode_control
  import limit_timer_pkg::*;
;
  logic               clk      = 1'h0;
  logic               rst      = 1'h1;
  logic [MODE_W-1:0]  mode     = 5'h00;
  logic [COUNT_W-1:0] period   = 8'hff;
  logic               on_wr    = 1'h0;
  logic               on_wdata = 1'h0;
  logic               ers_req  = 1'h0;
  logic               debug    = 1'h0;
  logic               ers;
  logic [COUNT_W-1:0] count;
  logic               on;
  logic               match;
  logic               running;
  int                 bad_count = 0;
  int                 checks    = 0;

  always #50 clk = ~clk;

  ers_source src (.clk_i(clk), .level_i(ers_req), .ers_o(ers));

  limit_timer_mode_control dut (
    .CLK_I(clk), .RESET_I(rst), .MODE_I(mode), .PERIOD_I(period),
    .ON_WR_I(on_wr), .ON_WDATA_I(on_wdata), .ERS_I(ers), .DEBUG_I(debug),
    .COUNT_O(count), .ON_O(on), .MATCH_O(match), .RUNNING_O(running)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'h1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr_on(input logic v);
    on_wr    = 1'h1;
    on_wdata = v;
    cyc(1);
    on_wr    = 1'h0;
    cyc(1);
  endtask

  task automatic set_ers(input logic v);
    int i;
    ers_req = v;
    i = 0;
    while (ers !== v && i < 12) begin
      @(posedge clk);
      i++;
    end
    cyc(4);
  endtask

  task automatic go(input logic [4:0] m, input logic [7:0] p);
    rst    = 1'h1;
    mode   = m;
    period = p;
    cyc(2);
    rst    = 1'h0;
    cyc(1);
    wr_on(1'h1);
  endtask

  task automatic expect_run(input logic run, input string msg);
    logic [COUNT_W-1:0] c;
    c = count;
    cyc(3);
    chk(count === (run ? c + 8'h03 : c), msg);
    chk(running === run, msg);
  endtask

  task automatic reset_seen(input logic v, input string msg);
    chk((count < 8'h06) === v, msg);
  endtask

  task automatic wait_match(input string msg);
    int i;
    i = 0;
    while (match !== 1'h1 && i < 300) begin
      cyc(1);
      i++;
    end
    chk(match === 1'h1 && count === 8'h00, msg);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_soft_gate();
    go({FAM_FREE, SUB_0}, 8'h03);
    wait_match("free wrap");
    chk(on === 1'h1, "free keeps enable");
    period = 8'hff;
    cyc(10);
    set_ers(1'h1);
    reset_seen(1'h0, "pin ignored");
    wr_on(1'h0);
    expect_run(1'h0, "halt");
  endtask

  task automatic t_levels();
    logic [2:0] s;
    logic       a;
    for (int k = 0; k < 4; k++) begin
      s = 3'(k < 2 ? k + 1 : k + 4);
      a = s[0] ^ s[2];
      set_ers(a);
      go({FAM_FREE, s}, 8'hff);
      expect_run(1'h1, "level active");
      set_ers(~a);
      expect_run(1'h0, "level inactive");
      if (s[2]) chk(count === 8'h00, "held");
    end
  endtask

  task automatic t_edge_reset();
    logic [2:0] s;
    for (int k = 3; k < 6; k++) begin
      s = 3'(k);
      set_ers(1'h0);
      go({FAM_FREE, s}, 8'hff);
      cyc(10);
      set_ers(1'h1);
      reset_seen(s != SUB_5, "rise reset");
      cyc(10);
      set_ers(1'h0);
      reset_seen(s != SUB_4, "fall reset");
    end
    debug = 1'h1;
    cyc(10);
    set_ers(1'h1);
    set_ers(1'h0);
    debug = 1'h0;
    cyc(4);
    reset_seen(1'h0, "debug ignores pin");
  endtask

  task automatic t_oneshot();
    go({FAM_ONESHOT, SUB_0}, 8'h10);
    expect_run(1'h1, "software start");
    wait_match("one-shot end");
    chk(on === 1'h0, "enable cleared");
    expect_run(1'h0, "stays stopped");
    for (int k = 1; k < 4; k++) begin
      set_ers(1'h0);
      go({FAM_ONESHOT, 3'(k)}, 8'hff);
      expect_run(1'h0, "waits for edge");
      set_ers(1'h1);
      expect_run(k != 2, "rise start");
      set_ers(1'h0);
      expect_run(1'h1, "fall start");
    end
    wr_on(1'h0);
    wr_on(1'h1);
    expect_run(1'h0, "re-enable waits");
    set_ers(1'h1);
    expect_run(1'h1, "fresh edge");
  endtask

  task automatic t_limit();
    set_ers(1'h0);
    go({FAM_ONESHOT, SUB_4}, 8'hff);
    set_ers(1'h1);
    cyc(10);
    set_ers(1'h0);
    reset_seen(1'h0, "fall ignored");
    cyc(6);
    set_ers(1'h1);
    reset_seen(1'h1, "rise resets");
    expect_run(1'h1, "keeps running");
    go({FAM_ONESHOT, SUB_6}, 8'hff);
    set_ers(1'h0);
    set_ers(1'h1);
    cyc(10);
    set_ers(1'h0);
    expect_run(1'h0, "low holds");
    chk(count === 8'h00, "low reset");
  endtask

  task automatic t_mono();
    set_ers(1'h0);
    go({FAM_MONO, SUB_1}, 8'h10);
    expect_run(1'h0, "mono waits");
    set_ers(1'h1);
    wait_match("mono end");
    chk(on === 1'h1, "enable kept");
    expect_run(1'h0, "stopped at zero");
    set_ers(1'h0);
    set_ers(1'h1);
    expect_run(1'h1, "restart");
    set_ers(1'h0);
    go({FAM_MONO, SUB_6}, 8'h40);
    expect_run(1'h0, "low holds");
    chk(count === 8'h00, "low reset");
    set_ers(1'h1);
    expect_run(1'h1, "high runs");
    go({FAM_MONO, SUB_0}, 8'hff);
    expect_run(1'h0, "reserved sub");
    go(5'h18, 8'hff);
    expect_run(1'h0, "reserved family");
  endtask

  initial begin
    cyc(10);
    rst = 1'h0;
    cyc(1);
    chk(count === 8'h00 && on === 1'h0 && match === 1'h0 && running === 1'h0, "reset");
    t_soft_gate();
    t_levels();
    t_edge_reset();
    t_oneshot();
    t_limit();
    t_mono();
    tally_and_finish();
  end

  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
